// [rtl/nvmrw_sequencer.sv]
// What this block does
// [R1] Erase accepts any address inside a row; low register 8 bits, high 7.
// [R2] Erase-select set makes an unlocked operation a row erase.
// [R3] Software disables interrupts around the unlock sequence.
// [R4] Operation starts only after 55h, AAh, then immediately the start bit.
// [R5] Software loads address, fills latches, starts, repeats until done.
// [R6] Programming never erases; it only drives bits toward zero.
// [R7] Exactly one row is erased per operation.
// [R8] One program operation writes at most 32 words of 14 bits.
// [R9] Row from high<6:0> and low<7:5>; low<4:0> picks the latch.
// [R10] Programming touches only the addressed row, never a neighbour.
// [R11] Latches return to 3FFF after every program and erase.
// [R12] Unloaded latches stay blank and leave words unprogrammed.
// [R13] Load-only set: unlocked write copies data pair into addressed latch.
// [R14] Load-only clear: load final latch, then program whole row.
// [R15] A broken unlock sequence loads nothing and programs nothing.
// [R16] Software sets write enable, clears region select, sets load-only.
// [R17] Software increments address after each load, repeats until last latch.
// [R18] Region clear: 0000h-07FFh is user flash, readable and writable.
// [R19] Region set: IDs writable, revision, device, calibration read-only.
// [R20] Region select redirects accesses to the information areas.
// [R21] Reads of empty region addresses clear the data pair to zero.
// [R22] Protected target clears the start bit and performs no erase.
// [R23] Erase completion sets done flag; interrupt if its enable is set.
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "nvmrw_defines.svh"

module nvmrw_sequencer
  import nvmrw_pkg::*;
#(
  parameter int          WORDS   = 2048,
  parameter int          WP_ROWS = 0,
  parameter logic [13:0] REV_ID  = 14'h0123,
  parameter logic [13:0] DEV_ID  = 14'h0456
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             flash_done_irq
);

  // ==========================================================
  // State
  nvmrw_aphase_t aph;
  nvmrw_ctrl_t   flash_control_reg;
  nvmrw_ctrl_t   wctrl;
  nvmrw_op_t     op;
  logic [7:0]    flash_addr_low;
  logic [6:0]    flash_addr_high;
  logic [7:0]    flash_data_low;
  logic [5:0]    flash_data_high;
  logic [1:0]    key_stage;
  logic [5:0]    op_cnt;
  logic [14:0]   full_addr;
  logic [13:0]   latch_q;
  logic [13:0]   rd_word;
  logic          rd_ok;
  logic          capture;
  logic          wr_apply;
  logic          rd_capture;
  logic          ctrl_wr;
  logic          start;
  logic          allowed;
  logic          load_we;
  logic          prog_we;
  logic          erase_we;
  logic          op_end;
  logic [31:0]   next_hrdata;

  // Target lies in a writable area and outside the protected rows
  function automatic logic target_ok(input logic regs, input logic [14:0] a);
    if (regs)
      target_ok = (a <= `NVMRW_UID_LAST);
    else
      target_ok = (a <= `NVMRW_PROGRAM_FLASH_LAST) && (32'(a[10:5]) >= WP_ROWS);
  endfunction

  // ==========================================================
  // Bus decode
  assign capture    = hsel && htrans[1] && hready;
  assign wr_apply   = hreadyout && aph.pend && aph.write;
  assign rd_capture = capture && !hwrite;
  assign ctrl_wr    = wr_apply && (aph.off == `NVMRW_OFF_CTRL);
  assign wctrl      = nvmrw_ctrl_t'(hwdata[7:0]);
  assign full_addr  = {flash_addr_high, flash_addr_low};
  assign allowed    = target_ok(flash_control_reg.regs, full_addr);   // [R18] [R19]
  // Start needs both keys then the start bit with write enable
  assign start      = ctrl_wr && (key_stage == 2'd2) && wctrl.wr
                      && wctrl.write_enable_bit && allowed;            // [R4] [R15] [R22]
  assign load_we    = start && !wctrl.free;                            // [R13] [R14]
  assign prog_we    = (op == NVMRW_PROG);
  assign erase_we   = (op == NVMRW_ERASE) && (op_cnt == 6'd0);         // [R7]
  assign op_end     = ((op == NVMRW_PROG) && (op_cnt[4:0] == `NVMRW_ROW_LAST))
                      || erase_we || (op == NVMRW_LOAD);

  // ==========================================================
  // Address phase capture
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      aph <= '0;
    else if (ce && hready)
      aph <= '{off: haddr[7:0], write: hwrite, pend: capture};
  end

  // ==========================================================
  // Unlock sequence tracking; any other access breaks it
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      key_stage <= 2'd0;
    else if (ce)
    begin
      if (wr_apply && aph.off == `NVMRW_OFF_KEY)
      begin
        if (hwdata[7:0] == `NVMRW_KEY_FIRST)
          key_stage <= 2'd1;                                           // [R4]
        else if (hwdata[7:0] == `NVMRW_KEY_SECOND && key_stage == 2'd1)
          key_stage <= 2'd2;                                           // [R4]
        else
          key_stage <= 2'd0;                                           // [R15]
      end
      else if (wr_apply || rd_capture)
        key_stage <= 2'd0;                                             // [R15]
    end
  end

  // ==========================================================
  // Control register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flash_control_reg <= '0;
    else if (ce)
    begin
      if (ctrl_wr)
      begin
        flash_control_reg.write_enable_bit <= wctrl.write_enable_bit;
        flash_control_reg.free   <= wctrl.free;
        flash_control_reg.latch_load_only <= wctrl.latch_load_only;
        flash_control_reg.regs   <= wctrl.regs;                        // [R20]
        flash_control_reg.irq_en <= wctrl.irq_en;
        flash_control_reg.wr     <= start;                             // [R22]
        if (!wctrl.done)
          flash_control_reg.done <= 1'b0;
      end
      if (op_end)
        flash_control_reg.wr <= 1'b0;
      // Completion set wins over a clearing write
      if (op_end && op != NVMRW_LOAD)
        flash_control_reg.done <= 1'b1;                                // [R23]
    end
  end

  // ==========================================================
  // Address and data registers, read operation
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      flash_addr_low  <= 8'h00;
      flash_addr_high <= 7'h00;
      flash_data_low  <= 8'h00;
      flash_data_high <= 6'h00;
    end
    else if (ce && wr_apply)
    begin
      case (aph.off)
        `NVMRW_OFF_ADRL: flash_addr_low  <= hwdata[7:0];               // [R1] [R9]
        `NVMRW_OFF_ADRH: flash_addr_high <= hwdata[6:0];               // [R1] [R9]
        `NVMRW_OFF_DATL: flash_data_low  <= hwdata[7:0];
        `NVMRW_OFF_DATH: flash_data_high <= hwdata[5:0];
        `NVMRW_OFF_CTRL:
        begin
          if (wctrl.rd)
          begin
            flash_data_low  <= rd_ok ? rd_word[7:0] : 8'h00;           // [R21]
            flash_data_high <= rd_ok ? rd_word[13:8] : 6'h00;          // [R21]
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Operation sequencer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      op     <= NVMRW_IDLE;
      op_cnt <= 6'd0;
    end
    else if (ce)
    begin
      case (op)
        NVMRW_IDLE:
        begin
          op_cnt <= 6'd0;
          if (start && wctrl.free)
          begin
            op     <= NVMRW_ERASE;                                     // [R2]
            op_cnt <= `NVMRW_ERASE_CYCLES;
          end
          else if (start && wctrl.latch_load_only)
            op <= NVMRW_LOAD;                                          // [R13]
          else if (start)
            op <= NVMRW_PROG;                                          // [R14]
        end
        NVMRW_ERASE:
        begin
          if (op_cnt == 6'd0)
            op <= NVMRW_IDLE;
          else
            op_cnt <= op_cnt - 6'd1;
        end
        NVMRW_PROG:
        begin
          // Walk the 32 latches of one row, no wrap
          if (op_cnt[4:0] == `NVMRW_ROW_LAST)
            op <= NVMRW_IDLE;                                          // [R8] [R10]
          else
            op_cnt <= op_cnt + 6'd1;
        end
        NVMRW_LOAD: op <= NVMRW_IDLE;
        default:    op <= NVMRW_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Bus answer: reads wait one cycle, operations stall the core
  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    case (aph.off)
      `NVMRW_OFF_CTRL: next_hrdata = {24'h000000, flash_control_reg};
      `NVMRW_OFF_ADRL: next_hrdata = {24'h000000, flash_addr_low};
      `NVMRW_OFF_ADRH: next_hrdata = {25'h0000000, flash_addr_high};
      `NVMRW_OFF_DATL: next_hrdata = {24'h000000, flash_data_low};
      `NVMRW_OFF_DATH: next_hrdata = {26'h0000000, flash_data_high};
      default:         next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      hresp <= 1'b0;
      if (op != NVMRW_IDLE)
        hreadyout <= 1'b0;
      else if (!hreadyout)
      begin
        hrdata    <= next_hrdata;
        hreadyout <= 1'b1;
      end
      else if (rd_capture || start)
        hreadyout <= 1'b0;
    end
  end

  // Completion interrupt request
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flash_done_irq <= 1'b0;
    else if (ce)
      flash_done_irq <= flash_control_reg.done && flash_control_reg.irq_en;  // [R23]
  end

  // ==========================================================
  // Write latches and array
  nvmrw_latch_bank #(
    .ROW_WORDS (32)
  ) u_latch (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .we      (load_we),                                                // [R13]
    .widx    (flash_addr_low[4:0]),                                    // [R9]
    .wdata   ({flash_data_high, flash_data_low}),
    .clear   (op_end && op != NVMRW_LOAD),                             // [R11] [R12]
    .ridx    (op_cnt[4:0]),
    .rdata   (latch_q)
  );

  nvmrw_flash_array #(
    .WORDS  (WORDS),
    .REV_ID (REV_ID),
    .DEV_ID (DEV_ID)
  ) u_array (
    .clk_sys  (clk_sys),
    .ce       (ce),
    .regs     (flash_control_reg.regs),                                // [R20]
    .rd_addr  (full_addr),
    .rd_data  (rd_word),
    .rd_valid (rd_ok),
    .prog_we  (prog_we),                                               // [R6]
    .erase_we (erase_we),                                              // [R1] [R7]
    .wr_addr  ({full_addr[14:5], op_cnt[4:0]}),                        // [R10]
    .wr_data  (latch_q)
  );

endmodule
`default_nettype wire

// [rtl/nvmrw_defines.svh]
`ifndef NVMRW_DEFINES_SVH
`define NVMRW_DEFINES_SVH

// ==========================================================
// Register offsets on the AHB-Lite slave
`define NVMRW_OFF_CTRL   8'h00
`define NVMRW_OFF_KEY    8'h04
`define NVMRW_OFF_ADRL   8'h08
`define NVMRW_OFF_ADRH   8'h0C
`define NVMRW_OFF_DATL   8'h10
`define NVMRW_OFF_DATH   8'h14

// ==========================================================
// Control field positions
`define NVMRW_CTRL_RD    0
`define NVMRW_CTRL_WR    1
`define NVMRW_CTRL_WRITE_ENABLE_BIT 2
`define NVMRW_CTRL_FREE  3
`define NVMRW_CTRL_LATCH_LOAD_ONLY  4
`define NVMRW_CTRL_REGS  5
`define NVMRW_CTRL_DONE  6
`define NVMRW_CTRL_IE    7

// ==========================================================
// Unlock keys, blank value, timing counts
`define NVMRW_KEY_FIRST  8'h55
`define NVMRW_KEY_SECOND 8'hAA
`define NVMRW_BLANK      14'h3FFF
`define NVMRW_ERASE_CYCLES 6'd8
`define NVMRW_ROW_LAST   5'h1F

// ==========================================================
// Region map with region select set, and the end of user flash
`define NVMRW_UID_LAST   15'h0003
`define NVMRW_REV_OFF    15'h0005
`define NVMRW_DEVID_OFF  15'h0006
`define NVMRW_CFG_FIRST  15'h0007
`define NVMRW_CFG_LAST   15'h000B
`define NVMRW_CAL_FIRST  15'h0100
`define NVMRW_CAL_LAST   15'h02FF
`define NVMRW_PROGRAM_FLASH_LAST 15'h07FF

`endif

// [rtl/nvmrw_pkg.sv]
package nvmrw_pkg;

  // ==========================================================
  // Sequencer operation states
  typedef enum logic [1:0] {
    NVMRW_IDLE  = 2'b00,
    NVMRW_LOAD  = 2'b01,
    NVMRW_ERASE = 2'b10,
    NVMRW_PROG  = 2'b11
  } nvmrw_op_t;

  // Captured AHB address phase
  typedef struct packed {
    logic [7:0] off;
    logic       write;
    logic       pend;
  } nvmrw_aphase_t;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic irq_en;
    logic done;
    logic regs;
    logic latch_load_only;
    logic free;
    logic write_enable_bit;
    logic wr;
    logic rd;
  } nvmrw_ctrl_t;

endpackage

// [rtl/nvmrw_latch_bank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nvmrw_defines.svh"

module nvmrw_latch_bank #(
  parameter int ROW_WORDS = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [4:0]  widx,
  input  wire logic [13:0] wdata,
  input  wire logic        clear,
  input  wire logic [4:0]  ridx,
  output logic      [13:0] rdata
);

  logic [13:0] latch [0:ROW_WORDS-1];

  // ==========================================================
  // Write latches, blank after reset and after each program or erase
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < ROW_WORDS; i++)
        latch[i] <= `NVMRW_BLANK;
    end
    else if (ce)
    begin
      if (clear)
      begin
        for (int i = 0; i < ROW_WORDS; i++)
          latch[i] <= `NVMRW_BLANK;
      end
      else if (we)
        latch[widx] <= wdata;
    end
  end

  // Asynchronous read by index
  assign rdata = latch[ridx];

endmodule
`default_nettype wire

// [rtl/nvmrw_flash_array.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nvmrw_defines.svh"

module nvmrw_flash_array #(
  parameter int          WORDS     = 2048,
  parameter logic [13:0] REV_ID    = 14'h0123,
  parameter logic [13:0] DEV_ID    = 14'h0456,
  parameter logic [13:0] CFG_VALUE = 14'h3FFF,
  parameter logic [13:0] CAL_VALUE = 14'h0000
) (
  input  wire logic        clk_sys,
  input  wire logic        ce,
  input  wire logic        regs,
  input  wire logic [14:0] rd_addr,
  output logic      [13:0] rd_data,
  output logic             rd_valid,
  input  wire logic        prog_we,
  input  wire logic        erase_we,
  input  wire logic [14:0] wr_addr,
  input  wire logic [13:0] wr_data
);

  // Identity values above are arbitrary
  logic [13:0] mem [0:WORDS-1];
  logic [13:0] uid [0:3];

  // ==========================================================
  // Programming only clears bits; erase blanks one row, or the four IDs with regs set
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      if (erase_we && !regs)
      begin
        for (int i = 0; i < 32; i++)
          mem[{wr_addr[10:5], 5'(i)}] <= `NVMRW_BLANK;
      end
      else if (erase_we && regs)
      begin
        for (int i = 0; i < 4; i++)
          uid[i] <= `NVMRW_BLANK;
      end
      else if (prog_we && !regs)
        mem[wr_addr[10:0]] <= mem[wr_addr[10:0]] & wr_data;
      else if (prog_we && regs && wr_addr <= `NVMRW_UID_LAST)
        uid[wr_addr[1:0]] <= uid[wr_addr[1:0]] & wr_data;
    end
  end

  // ==========================================================
  // Read decode; holes return zero with valid low
  always_comb
  begin
    rd_data  = 14'h0000;
    rd_valid = 1'b1;
    if (!regs)
      rd_data = mem[rd_addr[10:0]];
    else if (rd_addr <= `NVMRW_UID_LAST)
      rd_data = uid[rd_addr[1:0]];
    else if (rd_addr == `NVMRW_REV_OFF)
      rd_data = REV_ID;
    else if (rd_addr == `NVMRW_DEVID_OFF)
      rd_data = DEV_ID;
    else if (rd_addr >= `NVMRW_CFG_FIRST && rd_addr <= `NVMRW_CFG_LAST)
      rd_data = CFG_VALUE;
    else if (rd_addr >= `NVMRW_CAL_FIRST && rd_addr <= `NVMRW_CAL_LAST)
      rd_data = CAL_VALUE;
    else
      rd_valid = 1'b0;
  end

endmodule
`default_nettype wire

// [verif/nvmrw_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nvmrw_defines.svh"

module nvmrw_seq_assertions (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        flash_done_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic       pend, pwr, ie, take, dend, cwr, kwr, go;
  logic [7:0] poff;
  logic [1:0] kst;
  logic [5:0] lowc, elen;

  // ====
  // Bus phase decode
  assign take = ce && hsel && htrans[1] && hready;
  assign dend = ce && pend && hready;
  assign cwr  = dend && pwr && poff == `NVMRW_OFF_CTRL;
  assign kwr  = dend && pwr && poff == `NVMRW_OFF_KEY;
  assign go   = cwr && kst == 2'h2 && hwdata[1] && hwdata[2];
  // Address phase capture
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) {pend, pwr, poff} <= '0;
    else if (take) {pend, pwr, poff} <= {1'b1, hwrite, haddr[7:0]};
    else if (dend) pend <= 1'b0;
  // Unlock progress, any other access breaks it
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) kst <= 2'h0;
    else if (kwr && hwdata[7:0] == `NVMRW_KEY_FIRST) kst <= 2'h1;
    else if (kwr && hwdata[7:0] == `NVMRW_KEY_SECOND && kst == 2'h1) kst <= 2'h2;
    else if (dend) kst <= 2'h0;
  // Stall length seen and expected
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) lowc <= 6'h00;
    else if (ce) lowc <= hreadyout ? 6'h00 : lowc + 6'h01;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) elen <= 6'h00;
    else if (take && !hwrite) elen <= 6'h01;
    else if (go) elen <= hwdata[3] ? `NVMRW_ERASE_CYCLES + 6'h02 : (hwdata[4] ? 6'h02 : 6'h21);
  // Shadow of the interrupt enable
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn) ie <= 1'b0;
    else if (cwr) ie <= hwdata[7];

  // ====
  // Properties
  AST_NO_START: assert property (cwr && !go |=> hreadyout)
    else $error("operation started without unlock");
  AST_WRITE_WAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_STALL_LEN: assert property ($rose(hreadyout) |-> lowc == elen)
    else $error("stall length wrong");
  AST_KEY_ZERO: assert property (take && !hwrite && (haddr[7:0] == `NVMRW_OFF_KEY || haddr[7:0] >= 8'h18)
    |-> ##2 hrdata == 32'h0)
    else $error("key or unmapped read not zero");
  AST_CTRL_STROBES: assert property (take && !hwrite && haddr[7:0] == `NVMRW_OFF_CTRL
    |-> ##2 hrdata[1:0] == 2'h0)
    else $error("start or read bit reads set");
  AST_IRQ_GATED: assert property (flash_done_irq |-> $past(ie))
    else $error("interrupt without enable");
  AST_HRESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  COV_ERASE: cover property (go && hwdata[3]);
  COV_LOAD: cover property (go && !hwdata[3] && hwdata[4]);
  COV_PROG: cover property (go && !hwdata[3] && !hwdata[4]);
  COV_IRQ: cover property ($rose(flash_done_irq));
endmodule

bind nvmrw_sequencer nvmrw_seq_assertions chk_u (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_done_irq(flash_done_irq));
`default_nettype wire

// [verif/nvm_row_write_erase_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "nvmrw_defines.svh"

module nvm_row_write_erase_sequencer_tb;
  localparam logic [13:0] REV = 14'h0A5A; // Arbitrary value
  localparam logic [13:0] DEV = 14'h0C3C; // Arbitrary value
  logic        clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp, flash_done_irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  int          n_errors, total_checks;

  assign hready = hreadyout;
  nvmrw_sequencer #(.WP_ROWS(1), .REV_ID(REV), .DEV_ID(DEV)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_done_irq(flash_done_irq));

  // ====
  // Compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ====
  // Single AHB transfer, entered just after a rising edge
  task automatic xfer(input logic [7:0] off, input logic we, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, off};
    hwrite <= we;
    do @(posedge clk_sys); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (!hreadyout);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] v);
    xfer(off, 1'b1, {24'h0, v});
  endtask
  task automatic rd(input logic [7:0] off);
    xfer(off, 1'b0, 32'h0);
  endtask
  // Address and data pair
  task automatic setadr(input logic [14:0] a, input logic [13:0] v);
    wr(`NVMRW_OFF_ADRL, a[7:0]);
    wr(`NVMRW_OFF_ADRH, {1'b0, a[14:8]});
    wr(`NVMRW_OFF_DATL, v[7:0]);
    wr(`NVMRW_OFF_DATH, {2'h0, v[13:8]});
  endtask
  // Unlock then start
  task automatic op(input logic [7:0] c);
    wr(`NVMRW_OFF_KEY, `NVMRW_KEY_FIRST); // keys and start back to back
    wr(`NVMRW_OFF_KEY, `NVMRW_KEY_SECOND);
    wr(`NVMRW_OFF_CTRL, c);
  endtask
  // Read one flash word and compare
  task automatic word(input logic [14:0] a, input logic rg, input logic [13:0] exp);
    logic [7:0] lo;
    setadr(a, 14'h0000);
    wr(`NVMRW_OFF_CTRL, {2'h0, rg, 5'h00});
    wr(`NVMRW_OFF_CTRL, {2'h0, rg, 5'h01});
    rd(`NVMRW_OFF_DATL);
    lo = d[7:0];
    rd(`NVMRW_OFF_DATH);
    chk($sformatf("word %h", a), {18'h0, d[5:0], lo}, {18'h0, exp});
  endtask

  // ====
  // Clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end

  // ====
  // Test sequence
  initial
  begin
    rstn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4));
      chk("reset read", d, 32'h0);
    end
    for (int r = 1; r < 4; r++)
    begin
      setadr(15'(r * 32 + 7), 14'h0000);
      op(r == 3 ? 8'h8E : 8'h0E);
    end
    rd(`NVMRW_OFF_CTRL);
    chk("ctrl after erase", d, 32'hCC);
    chk("irq", {31'h0, flash_done_irq}, 32'h1);
    wr(`NVMRW_OFF_CTRL, 8'h00);
    rd(`NVMRW_OFF_CTRL);
    chk("irq cleared", {31'h0, flash_done_irq}, 32'h0);
    word(15'h0020, 1'b0, 14'h3FFF);
    word(15'h007F, 1'b0, 14'h3FFF);
    setadr(15'h0040, 14'h1234);
    op(8'h16);
    word(15'h0040, 1'b0, 14'h3FFF);
    setadr(15'h0045, 14'h0ABC);
    op(8'h16);
    setadr(15'h005F, 14'h2F0F);
    op(8'h06);
    word(15'h0040, 1'b0, 14'h1234);
    word(15'h0045, 1'b0, 14'h0ABC);
    word(15'h005F, 1'b0, 14'h2F0F);
    word(15'h0041, 1'b0, 14'h3FFF);
    word(15'h003F, 1'b0, 14'h3FFF);
    word(15'h0060, 1'b0, 14'h3FFF);
    setadr(15'h007F, 14'h3FF0);
    op(8'h06);
    word(15'h0065, 1'b0, 14'h3FFF);
    setadr(15'h0060, 14'h0000);
    op(8'h16);
    op(8'h0E);
    setadr(15'h007F, 14'h0FFF);
    op(8'h06);
    word(15'h0060, 1'b0, 14'h3FFF);
    setadr(15'h007F, 14'h3FF0);
    op(8'h06);
    word(15'h007F, 1'b0, 14'h0FF0);
    for (int v = 0; v < 3; v++)
    begin
      setadr(15'h0061, 14'h0000);
      wr(`NVMRW_OFF_KEY, v == 1 ? `NVMRW_KEY_SECOND : `NVMRW_KEY_FIRST);
      if (v == 0) rd(`NVMRW_OFF_ADRL);
      wr(`NVMRW_OFF_KEY, v == 1 ? `NVMRW_KEY_FIRST : `NVMRW_KEY_SECOND);
      if (v == 2) wr(`NVMRW_OFF_DATL, 8'h00);
      wr(`NVMRW_OFF_CTRL, 8'h06);
      rd(`NVMRW_OFF_CTRL);
      chk("start refused", d, 32'h04);
      word(15'h0061, 1'b0, 14'h3FFF);
    end
    setadr(15'h0010, 14'h0000);
    op(8'h0E);
    rd(`NVMRW_OFF_CTRL);
    chk("protected erase", {30'h0, d[6], d[1]}, 32'h0);
    wr(`NVMRW_OFF_CTRL, 8'h20);
    setadr(15'h0001, 14'h0000);
    op(8'h2E);
    setadr(15'h0002, 14'h0155);
    op(8'h26);
    setadr(15'h0005, 14'h0000);
    op(8'h26);
    word(15'h0002, 1'b1, 14'h0155);
    word(15'h0000, 1'b1, 14'h3FFF);
    word(15'h0005, 1'b1, REV);
    word(15'h0006, 1'b1, DEV);
    word(15'h0004, 1'b1, 14'h0000);
    word(15'h0300, 1'b1, 14'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
